//--- pkg/adcs_map.svh
`ifndef ADCS_MAP_SVH
`define ADCS_MAP_SVH
// register indices: byte address is four times the index
`define ADCS_IDX_MODE    16'hff80
`define ADCS_IDX_CHAN    16'hff81
`define ADCS_IDX_RESULT  16'hff82
`define ADCS_IDX_THRESH  16'hff83
`define ADCS_IDX_REFCTL  16'hff84
`define ADCS_IDX_PFMODE  16'hff86
`define ADCS_IDX_FLAG    16'hff87
// field positions
`define ADCS_BIT_RUN     7
`define ADCS_BIT_POWER_FAIL_ENABLE    7
`define ADCS_BIT_PFPOL   6
`define ADCS_BIT_FLAG    0
`define ADCS_BIT_REFEN   0
// reset values, then the first trial code and the first and last bit positions
`define ADCS_RST_BYTE    8'h00
`define ADCS_RST_WORD    32'h0000_0000
`define ADCS_RST_CHAN    2'h0
`define ADCS_RST_CNT     8'h00
`define ADCS_RST_BITP    3'h0
`define ADCS_SAR_MSB     8'h80
`define ADCS_BITP_MSB    3'h7
`define ADCS_BITP_LSB    3'h0
// timing: sampling and one comparison step, in ns, and clock period in ns
`define ADCS_SAMPLE_NS   400
`define ADCS_STEP_NS     100
`define ADCS_CLK_NS      20
`endif

//--- pkg/adcs_pkg.sv
package adcs_pkg;
  // converter sequencing states
  typedef enum logic [1:0] {
    ADCS_IDLE   = 2'b00,
    ADCS_SAMPLE = 2'b01,
    ADCS_CONV   = 2'b10
  } adcs_state_t;

  // software-owned configuration
  typedef struct packed {
    logic       run;
    logic       pf_en;
    logic       pf_pol;
    logic [1:0] chan;
    logic [7:0] thresh;
    logic       ref_en;
  } adcs_cfg_t;

  // approximation engine state
  typedef struct packed {
    adcs_state_t st;
    logic [7:0]  approximation_register;
    logic [2:0]  bitp;
    logic [7:0]  cnt;
    logic        first;
  } adcs_eng_t;
endpackage

//--- src/adcs_top.sv
`timescale 1ns/10ps
`include "adcs_map.svh"
// Notes on behaviour
// - standby stops conversion; run bit also stops
// - colliding result read returns old value first
// - mode/channel write beats result store, no flag
// - channel write leaves completion flag unchanged
// - conversion ending before rewrite still stores
// - result keeps its old value on a colliding mode/channel write
// - write-only reference register, resets zero
// - reference bit 0 enables reference control
// - reference register leaves converter behaviour untouched
// - back-to-back conversions; config write restarts
// - eight bits MSB first, latch, raise request
// - power-fail compare polarity selects request condition
// - no power-fail request on first conversion
module adcs_top (
  // system
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [17:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // device and analog side
  input  wire logic        standby_i,
  input  wire logic        comp_i,
  output logic      [7:0]  approximation_o,
  output logic      [1:0]  analog_input_channel_o,
  output logic             sample_o,
  output logic             conversion_end_flag_o,
  output logic             conversion_end_request_o,
  output logic             reference_control_enable_o
);
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int SAMPLE_CYC = (`ADCS_SAMPLE_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS;
  localparam int STEP_CYC   = (`ADCS_STEP_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS;
  localparam logic [7:0] SAMPLE_LD = 8'(SAMPLE_CYC - 1);
  localparam logic [7:0] STEP_LD   = 8'(STEP_CYC - 1);

  // address decode, shared by reads and writes
  function automatic logic dec(input logic [17:0] adr, input logic [15:0] idx);
    dec = (adr[17:2] == idx);
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] stby_s;
  logic [1:0] comp_s;
  // two flops each; only the second stage is read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stby_s <= 2'h0;
      comp_s <= 2'h0;
    end else begin
      stby_s <= {stby_s[0], standby_i};
      comp_s <= {comp_s[0], comp_i};
    end
  end
  wire logic standby = stby_s[1];
  wire logic comp    = comp_s[1];

  // ---------------------------------------------------------------
  // bus strobes
  // ---------------------------------------------------------------
  adcs_pkg::adcs_cfg_t cfg;
  adcs_pkg::adcs_cfg_t next_cfg;
  adcs_pkg::adcs_eng_t eng;
  adcs_pkg::adcs_eng_t next_eng;
  logic        ack;
  logic        next_ack;
  logic [31:0] dat;
  logic [31:0] next_dat;
  logic [7:0]  result;
  logic [7:0]  next_result;
  logic        flag;
  logic        next_flag;
  logic        req;
  logic        next_req;
  logic        wr;
  logic        wr_cfg;
  logic        done;
  logic        store;
  logic        raise;
  logic        pf_hit;
  logic [7:0]  resolved;

  // writes take effect on the edge where ack is high
  assign wr     = cyc_i & stb_i & we_i & ack & sel_i[0];
  assign wr_cfg = wr & (dec(adr_i, `ADCS_IDX_MODE) | dec(adr_i, `ADCS_IDX_CHAN));

  // ---------------------------------------------------------------
  // bus slave and configuration registers
  // ---------------------------------------------------------------
  // read data is sampled one cycle before ack, so a colliding store lands after it
  always_comb begin
    next_ack = cyc_i & stb_i & ~ack;
    next_dat = dat;
    next_cfg = cfg;
    if (cyc_i & stb_i & ~we_i & ~ack) begin
      next_dat = `ADCS_RST_WORD;
      if (dec(adr_i, `ADCS_IDX_MODE))   next_dat[`ADCS_BIT_RUN] = cfg.run;
      if (dec(adr_i, `ADCS_IDX_CHAN))   next_dat[1:0] = cfg.chan;
      if (dec(adr_i, `ADCS_IDX_RESULT)) next_dat[7:0] = result;
      if (dec(adr_i, `ADCS_IDX_THRESH)) next_dat[7:0] = cfg.thresh;
      if (dec(adr_i, `ADCS_IDX_PFMODE)) next_dat[7:6] = {cfg.pf_en, cfg.pf_pol};
      if (dec(adr_i, `ADCS_IDX_FLAG))   next_dat[`ADCS_BIT_FLAG] = flag;
      // reference register is write-only and reads as zero
    end
    if (wr) begin
      if (dec(adr_i, `ADCS_IDX_MODE))   next_cfg.run = dat_i[`ADCS_BIT_RUN];
      if (dec(adr_i, `ADCS_IDX_CHAN))   next_cfg.chan = dat_i[1:0];
      if (dec(adr_i, `ADCS_IDX_THRESH)) next_cfg.thresh = dat_i[7:0];
      if (dec(adr_i, `ADCS_IDX_PFMODE)) begin
        next_cfg.pf_en  = dat_i[`ADCS_BIT_POWER_FAIL_ENABLE];
        next_cfg.pf_pol = dat_i[`ADCS_BIT_PFPOL];
      end
      if (dec(adr_i, `ADCS_IDX_REFCTL)) next_cfg.ref_en = dat_i[`ADCS_BIT_REFEN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      dat <= `ADCS_RST_WORD;
      cfg <= '{run: 1'b0, pf_en: 1'b0, pf_pol: 1'b0, chan: `ADCS_RST_CHAN,
               thresh: `ADCS_RST_BYTE, ref_en: 1'b0};
    end else begin
      ack <= next_ack;
      dat <= next_dat;
      cfg <= next_cfg;
    end
  end

  // ---------------------------------------------------------------
  // approximation engine
  // ---------------------------------------------------------------
  // current trial bit resolved by the comparator
  always_comb begin
    resolved = eng.approximation_register;
    resolved[eng.bitp] = comp;
  end
  assign done   = (eng.st == adcs_pkg::ADCS_CONV) && (eng.cnt == `ADCS_RST_CNT) &&
                  (eng.bitp == `ADCS_BITP_LSB);
  assign store  = done & ~wr_cfg;
  assign pf_hit = cfg.pf_pol ? (resolved < cfg.thresh) : (resolved >= cfg.thresh);
  assign raise  = store & (~cfg.pf_en | (~eng.first & pf_hit));

  // a config write restarts from sampling; reference enable is not consulted here
  always_comb begin
    next_eng = eng;
    if (eng.cnt != `ADCS_RST_CNT) next_eng.cnt = eng.cnt - 8'h01;
    case (eng.st)
      adcs_pkg::ADCS_IDLE: begin
        next_eng.first = 1'b1;
        if (cfg.run) begin
          next_eng.st  = adcs_pkg::ADCS_SAMPLE;
          next_eng.cnt = SAMPLE_LD;
        end
      end
      adcs_pkg::ADCS_SAMPLE: begin
        if (eng.cnt == `ADCS_RST_CNT) begin
          next_eng.st   = adcs_pkg::ADCS_CONV;
          next_eng.approximation_register  = `ADCS_SAR_MSB;
          next_eng.bitp = `ADCS_BITP_MSB;
          next_eng.cnt  = STEP_LD;
        end
      end
      adcs_pkg::ADCS_CONV: begin
        if (eng.cnt == `ADCS_RST_CNT) begin
          next_eng.cnt = STEP_LD;
          if (eng.bitp == `ADCS_BITP_LSB) begin
            next_eng.st    = adcs_pkg::ADCS_SAMPLE;
            next_eng.cnt   = SAMPLE_LD;
            next_eng.approximation_register   = resolved;
            next_eng.first = 1'b0;
          end else begin
            next_eng.approximation_register = resolved;
            next_eng.approximation_register[eng.bitp - 3'h1] = 1'b1;
            next_eng.bitp = eng.bitp - 3'h1;
          end
        end
      end
      default: next_eng.st = adcs_pkg::ADCS_IDLE;
    endcase
    if (wr_cfg) begin
      next_eng.st  = next_cfg.run ? adcs_pkg::ADCS_SAMPLE : adcs_pkg::ADCS_IDLE;
      next_eng.cnt = SAMPLE_LD;
      if (!cfg.run) next_eng.first = 1'b1;
    end
    if (standby || !next_cfg.run) begin
      next_eng.st  = adcs_pkg::ADCS_IDLE;
      next_eng.cnt = `ADCS_RST_CNT;
    end
  end

  // ---------------------------------------------------------------
  // result and completion flag
  // ---------------------------------------------------------------
  // hardware set wins over a software clear in the same cycle
  always_comb begin
    next_result = store ? resolved : result;
    next_req    = raise;
    next_flag   = flag;
    if (wr && dec(adr_i, `ADCS_IDX_FLAG) && dat_i[`ADCS_BIT_FLAG]) next_flag = 1'b0;
    if (raise) next_flag = 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eng    <= '{st: adcs_pkg::ADCS_IDLE, approximation_register: `ADCS_RST_BYTE, bitp: `ADCS_RST_BITP,
                  cnt: `ADCS_RST_CNT, first: 1'b1};
      result <= `ADCS_RST_BYTE;
      flag   <= 1'b0;
      req    <= 1'b0;
    end else begin
      eng    <= next_eng;
      result <= next_result;
      flag   <= next_flag;
      req    <= next_req;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign dat_o                      = dat;
  assign ack_o                      = ack;
  assign approximation_o            = eng.approximation_register;
  assign analog_input_channel_o     = cfg.chan;
  assign sample_o                   = (eng.st == adcs_pkg::ADCS_SAMPLE);
  assign conversion_end_flag_o      = flag;
  assign conversion_end_request_o   = req;
  assign reference_control_enable_o = cfg.ref_en;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  flag_set_a: assert property (raise |=> flag && req) else $error("flag not set");
  cfg_wins_a: assert property (done && wr_cfg |=> !req && result == $past(result))
    else $error("store not discarded");
  chan_keep_a: assert property (wr && dec(adr_i, `ADCS_IDX_CHAN) && flag |=> flag)
    else $error("channel write cleared flag");
  standby_stop_a: assert property (standby |=> eng.st == adcs_pkg::ADCS_IDLE)
    else $error("conversion in standby");
  read_old_a: assert property (cyc_i && stb_i && !we_i && !ack && dec(adr_i, `ADCS_IDX_RESULT)
    |=> dat_o[7:0] == $past(result)) else $error("read not old value");
  ref_zero_a: assert property (ack && dec(adr_i, `ADCS_IDX_REFCTL) && !we_i |-> dat_o == 32'h0)
    else $error("reference register readable");
  pf_first_a: assert property (store && cfg.pf_en && eng.first |=> !req)
    else $error("request on first compare");
  restart_a: assert property (wr_cfg && next_cfg.run && !standby |=> sample_o && eng.cnt == SAMPLE_LD)
    else $error("no restart after config write");
  pf_pol_a: assert property (store && cfg.pf_en && !eng.first && cfg.pf_pol && resolved >= cfg.thresh
    |=> !req) else $error("wrong polarity request");
endmodule

//--- dv/adcs_tb.sv
`timescale 1ns/10ps
`include "adcs_map.svh"
module tb;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic        clk_i     = 1'b0;
  logic        rst_i     = 1'b1;
  logic        cyc_i     = 1'b0;
  logic        stb_i     = 1'b0;
  logic        we_i      = 1'b0;
  logic [17:0] adr_i     = 18'h00000;
  logic [3:0]  sel_i     = 4'h0;
  logic [31:0] dat_i     = 32'h00000000;
  logic        standby_i = 1'b0;
  logic        comp_i    = 1'b0;
  logic [7:0]  target    = 8'h00;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [7:0]  approximation_o;
  logic [1:0]  analog_input_channel_o;
  logic        sample_o;
  logic        conversion_end_flag_o;
  logic        conversion_end_request_o;
  logic        reference_control_enable_o;
  logic [31:0] rd;
  int          error_cnt   = 0;
  int          comparisons = 0;
  int          req_cnt     = 0;
  int          req0;
  // one conversion: sampling plus eight comparison steps, in clock cycles
  localparam int CONV_CYC = (`ADCS_SAMPLE_NS + 8 * `ADCS_STEP_NS) / `ADCS_CLK_NS;

  adcs_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .standby_i(standby_i), .comp_i(comp_i),
    .approximation_o(approximation_o), .analog_input_channel_o(analog_input_channel_o), .sample_o(sample_o),
    .conversion_end_flag_o(conversion_end_flag_o), .conversion_end_request_o(conversion_end_request_o),
    .reference_control_enable_o(reference_control_enable_o));

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  // ----------------------------------------
  // analog stand-in and request counter
  // ----------------------------------------
  // comparator answers for a fixed input level so the trial code converges on target
  always @(posedge clk_i) begin
    // the converting pin is only seen through the comparator, never by a port read
    comp_i <= (target >= approximation_o);
    if (conversion_end_request_o === 1'b1) req_cnt <= req_cnt + 1;
  end

  // ----------------------------------------
  // bus tasks and checks
  // ----------------------------------------
  task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'hf;
    dat_i <= {24'h000000, d};
    n = 0;
    // hold the request until ack is seen at a rising edge
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    if (n >= 50) error_cnt++;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    // one more edge, so that registers written at the ack edge are seen settled
    @(posedge clk_i);
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_flag();
    int n;
    n = 0;
    while (conversion_end_flag_o !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200) error_cnt++;
    @(posedge clk_i);
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    end_of_test();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values of mode and result, and an unmapped place, all read zero
    wb(1'b0, `ADCS_IDX_MODE, 8'h00);
    chk("mode", 32'h0, rd);
    wb(1'b0, `ADCS_IDX_RESULT, 8'h00);
    chk("result", 32'h0, rd);
    wb(1'b0, 16'hff85, 8'h00);
    chk("unmapped", 32'h0, rd);
    // only bit 0 is ever written as one; the upper bits stay zero
    wb(1'b1, `ADCS_IDX_REFCTL, 8'h01);
    chk("ref_en", 32'h1, {31'h0, reference_control_enable_o});
    wb(1'b0, `ADCS_IDX_REFCTL, 8'h00);
    chk("ref_read", 32'h0, rd);
    // plain conversion, MSB-first approximation reaches the input level
    target <= 8'ha5;
    wb(1'b1, `ADCS_IDX_CHAN, 8'h02);
    chk("chan", 32'h2, {30'h0, analog_input_channel_o});
    wb(1'b1, `ADCS_IDX_MODE, 8'h80);
    wait_flag();
    chk("req_cnt", 32'h1, 32'(req_cnt));
    // the result is read before any mode or channel write touches it
    wb(1'b0, `ADCS_IDX_RESULT, 8'h00);
    chk("result", 32'ha5, rd);
    // channel rewrite mid-conversion: flag kept, conversion restarts with sampling
    repeat (30) @(posedge clk_i);
    wb(1'b1, `ADCS_IDX_CHAN, 8'h01);
    chk("flag", 32'h1, {31'h0, conversion_end_flag_o});
    repeat (4) @(posedge clk_i);
    chk("sample", 32'h1, {31'h0, sample_o});
    wb(1'b1, `ADCS_IDX_FLAG, 8'h01);
    chk("flag", 32'h0, {31'h0, conversion_end_flag_o});
    // standby halts conversion
    standby_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk("sample", 32'h0, {31'h0, sample_o});
    repeat (150) @(posedge clk_i);
    chk("flag", 32'h0, {31'h0, conversion_end_flag_o});
    wb(1'b1, `ADCS_IDX_MODE, 8'h00);
    standby_i <= 1'b0;
    // power-fail compare: first conversion silent, then result >= threshold requests
    wb(1'b1, `ADCS_IDX_THRESH, 8'h80);
    wb(1'b1, `ADCS_IDX_PFMODE, 8'h80);
    req0 = req_cnt;
    wb(1'b1, `ADCS_IDX_MODE, 8'h80);
    repeat (70) @(posedge clk_i);
    chk("pf_first", 32'h0, 32'(req_cnt - req0));
    repeat (70) @(posedge clk_i);
    chk("pf_second", 32'h1, 32'(req_cnt - req0));
    // inverted polarity: result above threshold stays silent
    wb(1'b1, `ADCS_IDX_PFMODE, 8'hc0);
    req0 = req_cnt;
    repeat (130) @(posedge clk_i);
    chk("pf_inv", 32'h0, 32'(req_cnt - req0));
    // restart, then a channel write acknowledged in the very cycle the conversion ends
    wb(1'b1, `ADCS_IDX_PFMODE, 8'h00);
    wb(1'b1, `ADCS_IDX_FLAG, 8'h01);
    target <= 8'h3c;
    req0 = req_cnt;
    wb(1'b1, `ADCS_IDX_MODE, 8'h80);
    repeat (CONV_CYC - 4) @(posedge clk_i);
    wb(1'b1, `ADCS_IDX_CHAN, 8'h00);
    chk("cfg_flag", 32'h0, {31'h0, conversion_end_flag_o});
    chk("cfg_req", 32'h0, 32'(req_cnt - req0));
    wb(1'b0, `ADCS_IDX_RESULT, 8'h00);
    chk("cfg_result", 32'ha5, rd);
    // a channel write one cycle after the end still sees the store and the flag
    repeat (CONV_CYC - 7) @(posedge clk_i);
    wb(1'b1, `ADCS_IDX_CHAN, 8'h01);
    chk("late_flag", 32'h1, {31'h0, conversion_end_flag_o});
    chk("late_req", 32'h1, 32'(req_cnt - req0));
    wb(1'b0, `ADCS_IDX_RESULT, 8'h00);
    chk("late_result", 32'h3c, rd);
    end_of_test();
  end
endmodule
